// ===== hdl/ttc_pkg.sv
// package: constants, register map and types for the triple timer unit
package ttc_pkg;
  // register byte addresses on the axi4-lite bus
  localparam logic [7:0] ADDR_C01_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_C01_MODE  = 8'h04;
  localparam logic [7:0] ADDR_C0_LOW    = 8'h08;
  localparam logic [7:0] ADDR_C0_HIGH   = 8'h0c;
  localparam logic [7:0] ADDR_C1_LOW    = 8'h10;
  localparam logic [7:0] ADDR_C1_HIGH   = 8'h14;
  localparam logic [7:0] ADDR_C2_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_C2_LOW    = 8'h1c;
  localparam logic [7:0] ADDR_C2_HIGH   = 8'h20;
  localparam logic [7:0] ADDR_RLD_LOW   = 8'h24;
  localparam logic [7:0] ADDR_RLD_HIGH  = 8'h28;
  localparam logic [7:0] ADDR_CAP_BASE  = 8'h30;
  localparam logic [7:0] ADDR_CAP_CMD   = 8'h40;
  localparam logic [7:0] ADDR_FLAG_ACK  = 8'h44;
  // field positions
  localparam int FLD_TF1   = 7;
  localparam int FLD_TR1   = 6;
  localparam int FLD_TF0   = 5;
  localparam int FLD_TR0   = 4;
  localparam int FLD_GATE1 = 7;
  localparam int FLD_CT1   = 6;
  localparam int FLD_MODE1 = 4;
  localparam int FLD_GATE0 = 3;
  localparam int FLD_CT0   = 2;
  localparam int FLD_MODE0 = 0;
  localparam int FLD_PSEL  = 7;
  localparam int FLD_RLD   = 3;
  localparam int FLD_ISEL  = 0;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing
  localparam int          CLK_MHZ     = 200;
  localparam logic [4:0]  DIV_BASE    = 5'd12;
  localparam logic [4:0]  DIV_SLOW    = 5'd24;
  localparam int          LFCLK_DIV_W = 8;
  localparam logic [7:0]  LFCLK_DIV   = 8'hc8;
  localparam int          NUM_CAP     = 4;
  // mode encodings
  localparam logic [1:0] MODE_13BIT = 2'b00;
  localparam logic [1:0] MODE_16BIT = 2'b01;
  localparam logic [1:0] MODE_8RLD  = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
  localparam logic [1:0] ISEL_STOP  = 2'b00;
  localparam logic [1:0] ISEL_CLK   = 2'b01;
  localparam logic [1:0] ISEL_EVT   = 2'b10;
  localparam logic [1:0] ISEL_GATED = 2'b11;
  localparam logic [1:0] RLD_OVF    = 2'b10;
  localparam logic [1:0] RLD_TRIG   = 2'b11;

  typedef enum logic [2:0] {
    TTC_IDLE = 3'b001,
    TTC_RESP = 3'b010,
    TTC_RDAT = 3'b100
  } ttc_bus_e;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ttc_count_s;
endpackage

// ===== hdl/ttc_fall_det.sv
// falling edge detector on a synchronous input, one detection per edge
`timescale 1ns/10ps
module ttc_fall_det
  import ttc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      fall
);
  logic pin_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_r <= 1'b1;
    end else begin
      pin_r <= pin;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fall <= 1'b0;
    end else begin
      fall <= pin_r & ~pin;
    end
  end
endmodule

// ===== hdl/ttc_divider.sv
// programmable divider giving a one-cycle enable pulse
`timescale 1ns/10ps
module ttc_divider
  import ttc_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (cnt_r >= period - W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign tick = (cnt_r >= period - W'(1));
endmodule

// ===== hdl/ttc_top.sv
// three timer/counters with an axi4-lite register slave
`timescale 1ns/10ps
module ttc_top
  import ttc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        count_pin_zero,
  input  wire logic        count_pin_one,
  input  wire logic        count_pin_two,
  input  wire logic        gate_pin_zero,
  input  wire logic        gate_pin_one,
  input  wire logic        isr_enter_zero,
  input  wire logic        isr_enter_one,
  output logic             overflow_zero,
  output logic             overflow_one,
  output logic             counter1_baud_tick
);
  logic [7:0]  counter01_control_reg_r;
  logic [7:0]  counter01_mode_reg_r;
  logic [7:0]  counter2_control_r;
  ttc_count_s  cnt0_r, cnt1_r, cnt2_r, rld_r;
  logic [15:0] cap_r [NUM_CAP];
  logic        tf0_r, tf1_r;

  // ---- bus slave ----
  logic       aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_go;
  logic [7:0] ra;
  logic [7:0] rd_byte;
  logic       rd_ok;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  logic wr_hit;
  always_comb begin
    case (aw_addr_r)
      ADDR_C01_CTRL, ADDR_C01_MODE, ADDR_C0_LOW, ADDR_C0_HIGH,
      ADDR_C1_LOW, ADDR_C1_HIGH, ADDR_C2_CTRL, ADDR_C2_LOW,
      ADDR_C2_HIGH, ADDR_RLD_LOW, ADDR_RLD_HIGH, ADDR_CAP_CMD,
      ADDR_FLAG_ACK: wr_hit = 1'b1;
      default:       wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic       we;
  logic [7:0] wb;
  assign we = wr_go & w_strb_r[0];
  assign wb = w_data_r[7:0];

  always_comb begin
    ra      = s_axi_araddr;
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (ra)
      ADDR_C01_CTRL: rd_byte = counter01_control_reg_r;
      ADDR_C01_MODE: rd_byte = counter01_mode_reg_r;
      ADDR_C0_LOW:   rd_byte = cnt0_r.low;
      ADDR_C0_HIGH:  rd_byte = cnt0_r.high;
      ADDR_C1_LOW:   rd_byte = cnt1_r.low;
      ADDR_C1_HIGH:  rd_byte = cnt1_r.high;
      ADDR_C2_CTRL:  rd_byte = counter2_control_r;
      ADDR_C2_LOW:   rd_byte = cnt2_r.low;
      ADDR_C2_HIGH:  rd_byte = cnt2_r.high;
      ADDR_RLD_LOW:  rd_byte = rld_r.low;
      ADDR_RLD_HIGH: rd_byte = rld_r.high;
      ADDR_CAP_CMD, ADDR_FLAG_ACK: rd_byte = 8'h00;
      default: begin
        if (ra[7:4] == ADDR_CAP_BASE[7:4] && ra[1:0] == 2'b00) begin
          rd_byte = ra[2] ? cap_r[ra[3]][15:8]
                          : cap_r[ra[3]][7:0];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- prescalers and edges ----
  logic tick12, tick24, tick_lf;
  logic fall0, fall1, fall2, fall_ex;
  logic lf_half_r;

  ttc_divider #(.W(5)) u_div12 (
    .mclk   (mclk),
    .reset  (reset),
    .period (DIV_BASE),
    .tick   (tick12)
  );
  ttc_divider #(.W(5)) u_div24 (
    .mclk   (mclk),
    .reset  (reset),
    .period (DIV_SLOW),
    .tick   (tick24)
  );
  ttc_divider #(.W(LFCLK_DIV_W)) u_divlf (
    .mclk   (mclk),
    .reset  (reset),
    .period (LFCLK_DIV),
    .tick   (tick_lf)
  );
  ttc_fall_det u_fd0 (.mclk(mclk), .reset(reset), .pin(count_pin_zero),
                      .fall(fall0));
  ttc_fall_det u_fd1 (.mclk(mclk), .reset(reset), .pin(count_pin_one),
                      .fall(fall1));
  ttc_fall_det u_fd2 (.mclk(mclk), .reset(reset), .pin(count_pin_two),
                      .fall(fall2));
  ttc_fall_det u_fdx (.mclk(mclk), .reset(reset), .pin(lf_half_r),
                      .fall(fall_ex));

  // internal reload trigger: half of the low frequency clock
  // resets high to match the edge detector, so no false edge follows
  always_ff @(posedge mclk) begin
    if (reset) begin
      lf_half_r <= 1'b1;
    end else if (tick_lf) begin
      lf_half_r <= ~lf_half_r;
    end
  end

  // ---- step enables for counters zero and one ----
  logic [1:0] mode0, mode1;
  logic       run0, run1, run_hi;
  logic       step0, step1, step_hi;
  assign mode0 = counter01_mode_reg_r[FLD_MODE0+:2];
  assign mode1 = counter01_mode_reg_r[FLD_MODE1+:2];
  assign run0 = counter01_control_reg_r[FLD_TR0] &
    (~counter01_mode_reg_r[FLD_GATE0] | gate_pin_zero);
  assign run1 = counter01_control_reg_r[FLD_TR1] &
    (~counter01_mode_reg_r[FLD_GATE1] | gate_pin_one);
  assign run_hi = counter01_control_reg_r[FLD_TR1];
  assign step0 = run0 &
    (counter01_mode_reg_r[FLD_CT0] ? fall0 : tick12);
  assign step1 = run1 & (mode1 != MODE_SPLIT) &
    (counter01_mode_reg_r[FLD_CT1] ? fall1 : tick12);
  assign step_hi = run_hi & tick12 & (mode0 == MODE_SPLIT);

  // next value and overflow of one counter per mode
  function automatic logic [16:0] ttc_next(input ttc_count_s c,
                                           input logic [1:0] m);
    logic [8:0] lo9;
    ttc_next = {1'b0, c};
    lo9 = {1'b0, c.low} + 9'h001;
    case (m)
      MODE_13BIT: begin
        if (c.low[4:0] == 5'h1f) begin
          ttc_next = {(c.high == 8'hff), c.high + 8'h01,
                      c.low[7:5], 5'h00};
        end else begin
          ttc_next = {1'b0, c.high, c.low[7:5], c.low[4:0] + 5'h01};
        end
      end
      MODE_16BIT: ttc_next = {1'b0, c} + 17'h00001;
      MODE_8RLD: begin
        ttc_next = lo9[8] ? {1'b1, c.high, c.high}
                          : {1'b0, c.high, lo9[7:0]};
      end
      MODE_SPLIT: ttc_next = {lo9[8], c.high, lo9[7:0]};
      default:    ttc_next = {1'b0, c};
    endcase
  endfunction

  logic [16:0] n0, n1;
  logic [8:0]  hi_n;
  assign n0 = ttc_next(cnt0_r, mode0);
  assign n1 = ttc_next(cnt1_r, mode1);
  assign hi_n = {1'b0, cnt0_r.high} + 9'h001;

  // counter zero; in mode 3 its high byte is a separate timer
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt0_r <= '0;
    end else begin
      if (we && aw_addr_r == ADDR_C0_LOW) begin
        cnt0_r.low <= wb;
      end else if (step0) begin
        cnt0_r.low <= n0[7:0];
      end
      if (we && aw_addr_r == ADDR_C0_HIGH) begin
        cnt0_r.high <= wb;
      end else if (mode0 == MODE_SPLIT) begin
        if (step_hi) begin
          cnt0_r.high <= hi_n[7:0];
        end
      end else if (step0) begin
        cnt0_r.high <= n0[15:8];
      end
    end
  end

  // counter one keeps running in modes 0-2 beside split zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt1_r <= '0;
    end else if (we && aw_addr_r == ADDR_C1_LOW) begin
      cnt1_r.low <= wb;
    end else if (we && aw_addr_r == ADDR_C1_HIGH) begin
      cnt1_r.high <= wb;
    end else if (step1) begin
      cnt1_r <= n1[15:0];
    end
  end

  assign counter1_baud_tick = step1 & n1[16];

  // overflow flags: set wins over service clear
  logic ovf0, ovf1;
  assign ovf0 = step0 & n0[16];
  assign ovf1 = (mode0 == MODE_SPLIT) ? (step_hi & hi_n[8])
                                      : (step1 & n1[16]);
  always_ff @(posedge mclk) begin
    if (reset) begin
      tf0_r <= 1'b0;
      tf1_r <= 1'b0;
    end else begin
      if (ovf0) begin
        tf0_r <= 1'b1;
      end else if (isr_enter_zero |
                   (we && aw_addr_r == ADDR_FLAG_ACK && wb[0])) begin
        tf0_r <= 1'b0;
      end
      if (ovf1) begin
        tf1_r <= 1'b1;
      end else if (isr_enter_one |
                   (we && aw_addr_r == ADDR_FLAG_ACK && wb[1])) begin
        tf1_r <= 1'b0;
      end
    end
  end
  assign overflow_zero = tf0_r;
  assign overflow_one  = tf1_r;

  // control registers; flag bits read as copies of tf0_r and tf1_r, one cycle late
  always_ff @(posedge mclk) begin
    if (reset) begin
      counter01_control_reg_r <= RST_BYTE;
      counter01_mode_reg_r    <= RST_BYTE;
      counter2_control_r      <= RST_BYTE;
    end else begin
      counter01_control_reg_r[FLD_TF1] <= tf1_r;
      counter01_control_reg_r[FLD_TF0] <= tf0_r;
      if (we && aw_addr_r == ADDR_C01_CTRL) begin
        counter01_control_reg_r[FLD_TR1] <= wb[FLD_TR1];
        counter01_control_reg_r[FLD_TR0] <= wb[FLD_TR0];
        counter01_control_reg_r[3:0]     <= wb[3:0];
      end
      if (we && aw_addr_r == ADDR_C01_MODE) begin
        counter01_mode_reg_r <= wb;
      end
      if (we && aw_addr_r == ADDR_C2_CTRL) begin
        counter2_control_r <= wb;
      end
    end
  end

  // ---- counter two ----
  logic [1:0]  isel, rmode;
  logic        ptick, step2, rld2;
  logic [16:0] n2;
  assign isel  = counter2_control_r[FLD_ISEL+:2];
  assign rmode = counter2_control_r[FLD_RLD+:2];
  assign ptick = counter2_control_r[FLD_PSEL] ? tick24 : tick12;
  always_comb begin
    case (isel)
      ISEL_STOP:  step2 = 1'b0;
      ISEL_CLK:   step2 = ptick;
      ISEL_EVT:   step2 = fall2;
      ISEL_GATED: step2 = ptick & count_pin_two;
      default:    step2 = 1'b0;
    endcase
  end
  assign n2 = {1'b0, cnt2_r} + 17'h00001;
  always_comb begin
    case (rmode)
      RLD_OVF:  rld2 = step2 & n2[16];
      RLD_TRIG: rld2 = fall_ex;
      default:  rld2 = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt2_r <= '0;
    end else if (we && aw_addr_r == ADDR_C2_LOW) begin
      cnt2_r.low <= wb;
    end else if (we && aw_addr_r == ADDR_C2_HIGH) begin
      cnt2_r.high <= wb;
    end else if (rld2) begin
      cnt2_r <= rld_r;
    end else if (step2) begin
      cnt2_r <= n2[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rld_r <= '0;
    end else if (we && aw_addr_r == ADDR_RLD_LOW) begin
      rld_r.low <= wb;
    end else if (we && aw_addr_r == ADDR_RLD_HIGH) begin
      rld_r.high <= wb;
    end
  end

  // captures latch the live count; the counter keeps running
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CAP; i++) begin
        cap_r[i] <= 16'h0000;
      end
    end else if (we && aw_addr_r == ADDR_CAP_CMD) begin
      for (int i = 0; i < NUM_CAP; i++) begin
        if (wb[i]) begin
          cap_r[i] <= cnt2_r;
        end
      end
    end
  end
endmodule

// ===== dv/ttc_top_monitor.sv
// checker of register bus handshakes and the overflow_zero flag at the top ports
`timescale 1ns/10ps
module ttc_top_monitor
  import ttc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        isr_enter_zero,
  input wire logic        overflow_zero
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  b_after_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("address taken early");
  r_after_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read response");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  flag_keep_a: assert property (
    overflow_zero && !isr_enter_zero && !s_axi_wvalid
    && !$past(s_axi_wvalid) |=> overflow_zero)
    else $error("overflow flag lost");
endmodule

bind ttc_top ttc_top_monitor mon_u (
  .mclk          (mclk),
  .reset         (reset),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .isr_enter_zero(isr_enter_zero),
  .overflow_zero (overflow_zero)
);

// ===== dv/ttc_pin_model.sv
// event source model driving the three count pins
`timescale 1ns/10ps
module ttc_pin_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] n,
  input  wire logic [2:0] idle,
  output logic [2:0]      pins,
  output logic            busy
);
  logic [8:0] cnt_r;

  // one clock per level, n falling edges at the fastest legal rate
  always_ff @(posedge mclk) begin
    if (rst)
      cnt_r <= 9'h000;
    else if (go)
      cnt_r <= {n, 1'b0};
    else if (cnt_r != 9'h000)
      cnt_r <= cnt_r - 9'h001;
  end

  always_comb begin
    pins = idle;
    if (cnt_r != 9'h000)
      pins[sel] = cnt_r[0];
  end

  assign busy = (cnt_r != 9'h000);
endmodule

// ===== dv/testbench.sv
// self-checking bench of the triple timer unit
`timescale 1ns/10ps
module testbench
  import ttc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic        go = 1'b0;
  logic [1:0]  psel = 2'b00;
  logic [7:0]  pn = 8'h00;
  logic [2:0]  idle = 3'b111;
  logic [2:0]  pins;
  logic        busy;
  logic        isr0 = 1'b0;
  logic        isr1 = 1'b0;
  logic        ov0, ov1;
  logic        baud;
  logic        baud_seen = 1'b0;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;

  ttc_top dut_u (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_pin_zero(pins[0]),
    .count_pin_one(pins[1]), .count_pin_two(pins[2]),
    .gate_pin_zero(1'b1), .gate_pin_one(1'b1),
    .isr_enter_zero(isr0), .isr_enter_one(isr1),
    .overflow_zero(ov0), .overflow_one(ov1),
    .counter1_baud_tick(baud));

  ttc_pin_model pin_u (
    .mclk(mclk), .rst(reset), .go(go), .sel(psel), .n(pn), .idle(idle),
    .pins(pins), .busy(busy));

  always #2.5 mclk = ~mclk;

  // sticky record of the one-cycle baud pulse
  always @(posedge mclk) begin
    if (baud === 1'b1) baud_seen <= 1'b1;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h04, v[15:8]);
  endtask

  task automatic pulse(input logic [1:0] s, input logic [7:0] n);
    @(posedge mclk);
    go <= 1'b1;
    psel <= s;
    pn <= n;
    @(posedge mclk);
    go <= 1'b0;
    do @(posedge mclk); while (busy);
    repeat (4) @(posedge mclk);
  endtask

  task automatic t_c01;
    logic [15:0] v;
    rd(ADDR_C01_MODE, v[7:0]);
    chk({8'h0, v[7:0]}, 16'h0000, "mode reset");
    rd(8'hfc, v[7:0]);
    chk({14'h0, rsp}, 16'h0002, "unmapped");
    wr(8'hfc, 8'h55);
    chk({14'h0, rsp}, 16'h0002, "bad write");
    wr16(ADDR_C0_LOW, 16'h0000);
    wr(ADDR_C01_MODE, 8'h01);
    wr(ADDR_C01_CTRL, 8'h10);
    repeat (240) @(posedge mclk);
    wr(ADDR_C01_CTRL, 8'h00);
    rd16(ADDR_C0_LOW, v);
    chk({15'h0, v >= 19 && v <= 21}, 16'h1, "t0 rate");
    wr16(ADDR_C0_LOW, 16'h00fe);
    wr(ADDR_C01_MODE, 8'h05);
    wr(ADDR_C01_CTRL, 8'h10);
    pulse(2'd0, 8'd5);
    rd16(ADDR_C0_LOW, v);
    chk(v, 16'h0103, "t0 events");
    wr16(ADDR_C0_LOW, 16'hffff);
    wr(ADDR_C01_MODE, 8'h04);
    pulse(2'd0, 8'd1);
    rd16(ADDR_C0_LOW, v);
    chk(v, 16'h00e0, "13 bit wrap");
    chk({15'h0, ov0}, 16'h1, "flag0 set");
    isr0 <= 1'b1;
    @(posedge mclk);
    isr0 <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({15'h0, ov0}, 16'h0, "flag0 clear");
    $display("test c01 modes 0 1 done");
  endtask

  task automatic t_split;
    logic [15:0] v;
    wr16(ADDR_C1_LOW, 16'hf0fe);
    wr(ADDR_C01_MODE, 8'h60);
    wr(ADDR_C01_CTRL, 8'h40);
    pulse(2'd1, 8'd3);
    rd16(ADDR_C1_LOW, v);
    chk(v, 16'hf0f1, "auto reload");
    chk({15'h0, ov1}, 16'h1, "flag1 set");
    chk({15'h0, baud_seen}, 16'h1, "baud tick");
    isr1 <= 1'b1;
    @(posedge mclk);
    isr1 <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({15'h0, ov1}, 16'h0, "flag1 clear");
    wr16(ADDR_C1_LOW, 16'h0005);
    wr16(ADDR_C0_LOW, 16'h0000);
    wr(ADDR_C01_MODE, 8'h37);
    wr(ADDR_C01_CTRL, 8'h50);
    pulse(2'd1, 8'd4);
    pulse(2'd0, 8'd4);
    wr(ADDR_C01_CTRL, 8'h00);
    rd16(ADDR_C1_LOW, v);
    chk(v, 16'h0005, "c1 held");
    rd(ADDR_C0_LOW, v[7:0]);
    chk({8'h0, v[7:0]}, 16'h0004, "c0 low split");
    $display("test modes 2 3 done");
  endtask

  task automatic t_c2;
    logic [15:0] v;
    logic        ok;
    logic [7:0]  cfg[4] = '{8'h01, 8'h81, 8'h03, 8'h03};
    logic [15:0] lo[4] = '{16'd19, 16'd9, 16'd0, 16'd19};
    logic [15:0] hi[4] = '{16'd21, 16'd11, 16'd0, 16'd21};
    logic [7:0]  rc[2] = '{8'h08, 8'h18};
    wr16(ADDR_C2_LOW, 16'h0000);
    wr(ADDR_C2_CTRL, 8'h02);
    pulse(2'd2, 8'd6);
    wr(ADDR_C2_CTRL, 8'h00);
    pulse(2'd2, 8'd3);
    rd16(ADDR_C2_LOW, v);
    chk(v, 16'h0006, "c2 events");
    for (int i = 0; i < 4; i++) begin
      idle[2] <= (i != 2);
      wr16(ADDR_C2_LOW, 16'h0000);
      wr(ADDR_C2_CTRL, cfg[i]);
      repeat (240) @(posedge mclk);
      wr(ADDR_C2_CTRL, 8'h00);
      rd16(ADDR_C2_LOW, v);
      ok = v >= lo[i] && v <= hi[i];
      chk({15'h0, ok}, 16'h1, "c2 rate");
    end
    wr16(ADDR_RLD_LOW, 16'h1234);
    wr16(ADDR_C2_LOW, 16'hffff);
    wr(ADDR_C2_CTRL, 8'h12);
    pulse(2'd2, 8'd2);
    rd16(ADDR_C2_LOW, v);
    chk(v, 16'h1235, "ovf reload");
    wr16(ADDR_RLD_LOW, 16'h00ab);
    for (int i = 0; i < 2; i++) begin
      wr16(ADDR_C2_LOW, 16'h0000);
      wr(ADDR_C2_CTRL, rc[i]);
      repeat (900) @(posedge mclk);
      rd16(ADDR_C2_LOW, v);
      chk(v, i ? 16'h00ab : 16'h0000, "trig reload");
    end
    wr(ADDR_CAP_CMD, 8'h01);
    rd16(ADDR_CAP_BASE, v);
    chk(v, 16'h00ab, "capture");
    $display("test counter two done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_c01();
    t_split();
    t_c2();
    results();
  end
endmodule
